// ===== tb/asp_host_model.sv
`timescale 1ns/100ps
// ==========================================================
// serial host, link clock idles high between frames
module asp_host (
  output logic sclk,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic so_o,
  input wire logic so_oe
);
  initial begin
    sclk = 1'b1;
    chip_select_n = 1'b1;
    serial_in = 1'b1;
  end
  task sel(input logic v);
    #3 chip_select_n = !v;
    #200;
  endtask
  // low ready level taken as data waiting
  task wait_rdy(output logic got);
    got = 1'b0;
    repeat (4000) begin
      #8;
      if (so_oe && so_o === 1'b0) begin
        got = 1'b1;
        break;
      end
    end
  endtask
  // input changes at the fall, stable over the rise
  task frame(input logic [31:0] tx, output logic [31:0] rx, output logic ok);
    ok = 1'b1;
    for (int i = 31; i >= 0; i--) begin
      #80 sclk = 1'b0;
      serial_in = tx[i];
      #80 sclk = 1'b1;
      rx[i] = so_o;
      #78;
      // output must still match its rise value 78 ns after the rise
      // last bit gives way to the ready level once the word is in
      if ((i > 0 && so_o !== rx[i]) || so_oe !== 1'b1) ok = 1'b0;
      #2;
    end
    // released data line carries no stale value
    serial_in = !tx[0];
  endtask
endmodule

// ===== tb/asp_serial_port_chk.sv
`timescale 1ns/100ps
// ==========================================================
// pin behaviour checks
module asp_chk (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic result_valid,
  input wire logic result_ready,
  input wire logic result_update_soon,
  input wire logic serial_out_ready_o,
  input wire logic serial_out_ready_oe,
  input wire logic filter_align_fault_pin_oe,
  input wire logic filter_align_pulse,
  input wire logic xtal_clock_io_o,
  input wire logic xtal_clock_io_oe,
  input wire logic int_osc_clk,
  input wire logic crystal_amp_en,
  input wire logic [1:0] clock_source_sel
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic [4:0] hi_cnt;
  // link clock high longer than half a period: no frame running, or late in the host's 160 ns high phase of a bit
  always_ff @(posedge clk_sys) begin
    if (!rstn || !sclk) begin
      hi_cnt <= 5'h00;
    end else if (hi_cnt != 5'h1F) begin
      hi_cnt <= hi_cnt + 5'h01;
    end
  end
  sequence idle_take;
    (!chip_select_n && hi_cnt > 5'h0E)[*4] ##0
      (result_valid && result_ready && !result_update_soon);
  endsequence
  sequence update_hold;
    (!chip_select_n && hi_cnt > 5'h0E && result_update_soon)[*8];
  endsequence
  a_ready_low: assert property (idle_take |-> ##[1:4] !serial_out_ready_o)
    else $error("ready pin not low after result");
  a_ready_high: assert property (update_hold |-> serial_out_ready_o)
    else $error("ready pin low before update");
  a_cs_release: assert property (chip_select_n[*4] |-> !serial_out_ready_oe)
    else $error("output pin driven while deselected");
  a_cs_select: assert property ((!chip_select_n)[*4] |-> serial_out_ready_oe)
    else $error("output pin released while selected");
  a_xtal_drive: assert property (xtal_clock_io_oe == (clock_source_sel == 2'h1))
    else $error("clock pin enable wrong");
  a_clk_out: assert property (xtal_clock_io_oe |-> xtal_clock_io_o == int_osc_clk)
    else $error("clock pin not oscillator");
  a_xtal_amp: assert property (crystal_amp_en == (clock_source_sel == 2'h3))
    else $error("crystal amplifier enable wrong");
  a_align_once: assert property (filter_align_pulse |=> !filter_align_pulse)
    else $error("align pulse longer than one cycle");
  a_align_input: assert property (filter_align_pulse |-> !filter_align_fault_pin_oe)
    else $error("align pulse while pin is output");
endmodule

bind asp_serial_port asp_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .sclk(sclk),
  .chip_select_n(chip_select_n), .result_valid(result_valid), .result_ready(result_ready),
  .result_update_soon(result_update_soon), .serial_out_ready_o(serial_out_ready_o),
  .serial_out_ready_oe(serial_out_ready_oe),
  .filter_align_fault_pin_oe(filter_align_fault_pin_oe),
  .filter_align_pulse(filter_align_pulse), .xtal_clock_io_o(xtal_clock_io_o),
  .xtal_clock_io_oe(xtal_clock_io_oe), .int_osc_clk(int_osc_clk),
  .crystal_amp_en(crystal_amp_en), .clock_source_sel(clock_source_sel));

// ===== tb/tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
// ==========================================================
// bench top
module tb;
  import asp_pkg::*;
  logic clk_sys, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, res_d;
  logic [1:0] bresp, rresp, csel;
  logic res_v, res_rdy, upd, align, amp, sclk, csn, sin, so_o, so_oe;
  logic fp_o, fp_oe, fp_drv, xo, xoe, osc, ext_clk;
  logic [3:0] err;
  logic [33:0] e_now;
  logic [33:0] exp_q[$];
  logic [31:0] mq[$];
  int n_fail = 0;
  int checks = 0;
  // shared line with pull-up; bench only ever pulls it low
  wire fpin = (fp_oe ? fp_o : 1'b1) & !fp_drv;
  wire xpin = xoe ? xo : ext_clk;

  asp_serial_port dut (
    .clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .result_data(res_d), .result_valid(res_v), .result_ready(res_rdy),
    .result_update_soon(upd), .error_bits(err), .filter_align_pulse(align),
    .sclk(sclk), .chip_select_n(csn), .serial_in(sin), .serial_out_ready_o(so_o),
    .serial_out_ready_oe(so_oe), .filter_align_fault_pin_i(fpin),
    .filter_align_fault_pin_o(fp_o), .filter_align_fault_pin_oe(fp_oe),
    .xtal_clock_io_i(xpin), .xtal_clock_io_o(xo), .xtal_clock_io_oe(xoe),
    .int_osc_clk(osc), .crystal_amp_en(amp), .clock_source_sel(csel));

  // a released output shows the inverse of its last value to the host
  asp_host host (.sclk(sclk), .chip_select_n(csn), .serial_in(sin),
    .so_o(so_oe ? so_o : !so_o), .so_oe(so_oe));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    osc = 1'b0;
    ext_clk = 1'b0;
    forever begin
      #13 osc = ~osc;
      #11 ext_clk = ~ext_clk;
    end
  end

  always @(posedge clk_sys) begin
    if (bvalid && bready && exp_q.size() > 0) begin
      e_now = exp_q.pop_front();
      `CHK({bresp, 32'h0}, e_now)
    end
    if (rvalid && rready && exp_q.size() > 0) begin
      e_now = exp_q.pop_front();
      `CHK({rresp, rdata}, e_now)
    end
  end

  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    exp_q.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) bready <= 1'b0;
    end while ((awvalid || wvalid || bready) && n < 500);
    if (n >= 500) n_fail++;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    exp_q.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) rready <= 1'b0;
    end while ((arvalid || rready) && n < 500);
    if (n >= 500) n_fail++;
  endtask
  task push(input logic [31:0] d);
    int n;
    n = 0;
    res_d <= d;
    res_v <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!res_rdy && n < 500);
    res_v <= 1'b0;
    if (n >= 500) n_fail++;
  endtask
  task report_and_stop;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #600000;
    n_fail++;
    report_and_stop;
  end

  initial begin
    logic [31:0] rx, w1, w2;
    logic ok, got;
    logic [2:0] k;
    int n, np;
    {awvalid, wvalid, bready, arvalid, rready, res_v, upd, fp_drv} = 8'h00;
    {awaddr, araddr, wdata, res_d, err} = '0;
    rstn = 1'b0;
    void'($urandom(32'hC765));
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(OFS_GPIO_CONFIG, RST_GPIO_CONFIG, AXI_OKAY);
    rd(OFS_ADC_MODE, RST_ADC_MODE, AXI_OKAY);
    rd(OFS_COMM, RST_COMM, AXI_OKAY);
    rd(8'h40, 32'h0, AXI_SLVERR);
    wr(OFS_STATUS, 32'hF, AXI_SLVERR);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_ADC_MODE, i, AXI_OKAY);
      rd(OFS_ADC_MODE, i, AXI_OKAY);
      cyc(2);
      `CHK(csel, i[1:0])
    end
    wr(OFS_GPIO_CONFIG, 32'h0, AXI_OKAY);
    fp_drv <= 1'b1;
    cyc(4);
    rd(OFS_STATUS, 32'h1, AXI_OKAY);
    fp_drv <= 1'b0;
    cyc(4);
    wr(OFS_COMM, 32'h0, AXI_OKAY);
    rd(OFS_STATUS, 32'h0, AXI_OKAY);
    wr(OFS_GPIO_CONFIG, 32'h2, AXI_OKAY);
    err <= 4'($urandom_range(15, 1));
    cyc(4);
    `CHK({fp_oe, fp_o, fpin}, 3'b100)
    err <= 4'h0;
    cyc(4);
    `CHK({fp_oe, fpin}, 2'b01)
    for (int lv = 0; lv < 2; lv++) begin
      wr(OFS_GPIO_CONFIG, 32'h4 | (lv << 3), AXI_OKAY);
      cyc(4);
      `CHK({fp_oe, fp_o}, {1'b1, lv[0]})
    end
    wr(OFS_GPIO_CONFIG, 32'h6, AXI_OKAY);
    cyc(4);
    `CHK(fp_oe, 1'b0)
    wr(OFS_GPIO_CONFIG, 32'h1, AXI_OKAY);
    fp_drv <= 1'b1;
    cyc(6);
    fp_drv <= 1'b0;
    np = 0;
    repeat (12) begin
      @(posedge clk_sys);
      if (align === 1'b1) np++;
    end
    `CHK(np, 1)
    `CHK(fp_oe, 1'b0)
    k = 3'($urandom_range(7, 0));
    w1 = $urandom;
    w2 = $urandom;
    wr(OFS_COMM, {29'h0, k}, AXI_OKAY);
    host.sel(1'b1);
    host.frame(w1, rx, ok);
    cyc(8);
    rd(OFS_CTRL_WORD, w1, AXI_OKAY);
    host.frame(w2, rx, ok);
    `CHK(rx, w1)
    `CHK(ok, 1'b1)
    cyc(8);
    rd(OFS_CTRL_WORD, w2, AXI_OKAY);
    w1 = $urandom;
    push(w1);
    host.wait_rdy(got);
    `CHK(got, 1'b1)
    host.frame(32'h0, rx, ok);
    `CHK(rx, w1)
    cyc(8);
    `CHK(so_o, 1'b1)
    n = 0;
    res_d <= $urandom;
    res_v <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (res_rdy) begin
        mq.push_back(res_d);
        res_d <= $urandom;
        n++;
      end
    end while (res_rdy && n < 40);
    res_v <= 1'b0;
    `CHK(n >= FIFO_DEPTH, 1'b1)
    while (mq.size() > 0) begin
      cyc($urandom_range(40, 5));
      host.wait_rdy(got);
      `CHK(got, 1'b1)
      host.frame(32'h0, rx, ok);
      w2 = mq.pop_front();
      `CHK(rx, w2)
    end
    cyc(8);
    `CHK(so_o, 1'b1)
    push($urandom);
    host.wait_rdy(got);
    @(posedge clk_sys);
    upd <= 1'b1;
    cyc(12);
    `CHK(so_o, 1'b1)
    upd <= 1'b0;
    host.sel(1'b0);
    `CHK(so_oe, 1'b0)
    report_and_stop;
  end
endmodule

// ===== verilog/asp_fifo.sv
`timescale 1ns/100ps
module asp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== verilog/asp_pkg.sv
package asp_pkg;
  // ==========================================================
  // register offsets (AXI4-Lite byte addresses)
  localparam logic [7:0] OFS_GPIO_CONFIG = 8'h00;
  localparam logic [7:0] OFS_ADC_MODE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_CTRL_WORD = 8'h10;
  localparam logic [7:0] OFS_COMM = 8'h14;
  // ==========================================================
  // field positions
  localparam int GPC_SYNC_EN = 0;
  localparam int GPC_MODE_LO = 1;
  localparam int GPC_ERR_LEVEL = 3;
  localparam int ST_EXT_FAULT = 0;
  localparam int ST_ERR_LO = 0;
  localparam int ST_ERR_HI = 3;
  localparam int ST_RESULT_READY = 4;
  localparam int ST_ALIGN_SEEN = 5;
  localparam int ADC_MODE_CLK_LO = 0;
  // ==========================================================
  // reset values
  localparam logic [31:0] RST_GPIO_CONFIG = 32'h0000_0000;
  localparam logic [31:0] RST_ADC_MODE = 32'h0000_0000;
  localparam logic [31:0] RST_COMM = 32'h0000_0000;
  // ==========================================================
  // sizes and codes
  localparam int DATA_W = 32;
  localparam int NUM_CTRL = 8;
  localparam int CTRL_AW = 3;
  localparam int FIFO_DEPTH = 16;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // link clock period 240 ns, result must leave ready a few cycles before update
  localparam int PRE_UPDATE_NS = 80;
  localparam int CLK_NS = 8;
  localparam int PRE_UPDATE_CYC = PRE_UPDATE_NS / CLK_NS;

  typedef enum logic [1:0] {
    ASP_PIN_FAULT_IN = 2'h0,
    ASP_PIN_FAULT_OUT = 2'h1,
    ASP_PIN_GP_OUT = 2'h2,
    ASP_PIN_RSVD = 2'h3
  } asp_pin_mode_e;

  typedef enum logic [1:0] {
    ASP_CLK_INT = 2'h0,
    ASP_CLK_INT_OUT = 2'h1,
    ASP_CLK_EXT = 2'h2,
    ASP_CLK_XTAL = 2'h3
  } asp_clk_src_e;

  // serial frame states, gray coded along idle->shift->done
  typedef enum logic [1:0] {
    ASP_IDLE = 2'h0,
    ASP_SHIFT = 2'h1,
    ASP_DONE = 2'h3
  } asp_state_e;

  typedef struct packed {
    logic o;
    logic oe;
  } asp_pin_drv_s;

  typedef struct packed {
    logic [CTRL_AW-1:0] addr;
    logic [DATA_W-1:0] data;
  } asp_word_s;
endpackage

// ===== verilog/asp_serial_port.sv
`timescale 1ns/100ps
// How it works
// - Each outgoing bit changes on a falling serial clock edge so it is stable at the next rise.
// - With chip select high the output/ready pin is released (output enable low).
// - Selected and idle, the output/ready pin drives low once a result is completed.
// - An unread result returns the ready pin high shortly before the next result update.
// - Serial input is captured on every rising serial clock edge while a selected frame is shifting.
// - A shifted-in word goes to the control register chosen by the address field.
// - The output shift register loads the register being read and shifts it out.
// - Chip select is active low; tying it low gives three-wire operation.
// - The sync/fault pin is an input or an output as set in the pin configuration register.
// - With sync enabled the pin input realigns the filters and modulators.
// - In fault input mode a low pin sets the external fault flag.
// - In fault output mode the pin is an active-low open drain of the error bits.
// - In general-purpose output mode the pin drives the stored level with active pull-up.
// - Clock source choices include external clock on the clock pin and a crystal.
// - Four clock sources are chosen by the clock source field of the mode register.
module asp_serial_port
  import asp_pkg::*;
#(
  parameter int WORD_W = DATA_W
) (
  input wire logic clk_sys,
  input wire logic rstn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // conversion engine side
  input wire logic [WORD_W-1:0] result_data,
  input wire logic result_valid,
  output logic result_ready,
  input wire logic result_update_soon,
  input wire logic [3:0] error_bits,
  output logic filter_align_pulse,
  // serial pins
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  output logic serial_out_ready_o,
  output logic serial_out_ready_oe,
  // sync / fault pin
  input wire logic filter_align_fault_pin_i,
  output logic filter_align_fault_pin_o,
  output logic filter_align_fault_pin_oe,
  // clock source pins
  input wire logic xtal_clock_io_i,
  output logic xtal_clock_io_o,
  output logic xtal_clock_io_oe,
  input wire logic int_osc_clk,
  output logic crystal_amp_en,
  output logic [1:0] clock_source_sel
);
  import asp_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic [1:0] sclk_sy, cs_sy, din_sy, pin_sy;
  // link clock idles high, so its synchroniser and edge history start high: no false edge
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sclk_sy <= 2'h3;
      cs_sy <= 2'h3;
      din_sy <= 2'h0;
      pin_sy <= 2'h3;
    end else begin
      sclk_sy <= {sclk_sy[0], sclk};
      cs_sy <= {cs_sy[0], chip_select_n};
      din_sy <= {din_sy[0], serial_in};
      pin_sy <= {pin_sy[0], filter_align_fault_pin_i};
    end
  end

  logic sclk_d, pin_d;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sclk_d <= 1'b1;
      pin_d <= 1'b1;
    end else begin
      sclk_d <= sclk_sy[1];
      pin_d <= pin_sy[1];
    end
  end
  logic sclk_rise, sclk_fall, selected;
  assign sclk_rise = sclk_sy[1] && !sclk_d;
  assign sclk_fall = !sclk_sy[1] && sclk_d;
  assign selected = !cs_sy[1];

  // ==========================================================
  // registers
  logic [31:0] gpio_config_reg, adc_mode_reg, comm_reg;
  logic [WORD_W-1:0] ctrl_regs [NUM_CTRL];
  logic external_fault_flag, align_seen;
  logic [WORD_W-1:0] result_word;
  logic result_pending;

  asp_pin_mode_e pin_mode;
  logic sync_en;
  assign sync_en = gpio_config_reg[GPC_SYNC_EN];
  // reserved code falls back to fault input so one mode is always active
  assign pin_mode = (gpio_config_reg[GPC_MODE_LO +: 2] == ASP_PIN_RSVD) ? ASP_PIN_FAULT_IN :
                    asp_pin_mode_e'(gpio_config_reg[GPC_MODE_LO +: 2]);

  function automatic logic [31:0] status_word(input logic f, input logic [3:0] e,
                                              input logic r, input logic a);
    status_word = 32'h0;
    status_word[ST_ERR_HI:ST_ERR_LO] = e;
    status_word[ST_EXT_FAULT] = e[0] | f;
    status_word[ST_RESULT_READY] = r;
    status_word[ST_ALIGN_SEEN] = a;
  endfunction

  // ==========================================================
  // AXI4-Lite write path
  logic aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go, wr_hit;
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign wr_go = aw_hold && w_hold && !s_axi_bvalid;
  assign wr_hit = (aw_addr == OFS_GPIO_CONFIG) || (aw_addr == OFS_ADC_MODE) ||
                  (aw_addr == OFS_COMM);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      gpio_config_reg <= RST_GPIO_CONFIG;
      adc_mode_reg <= RST_ADC_MODE;
      comm_reg <= RST_COMM;
    end else if (wr_go) begin
      if (aw_addr == OFS_GPIO_CONFIG) gpio_config_reg <= merge(gpio_config_reg, w_data, w_strb);
      if (aw_addr == OFS_ADC_MODE) adc_mode_reg <= merge(adc_mode_reg, w_data, w_strb);
      if (aw_addr == OFS_COMM) comm_reg <= merge(comm_reg, w_data, w_strb);
    end
  end

  // ==========================================================
  // serial frame engine
  asp_state_e state;
  logic [WORD_W-1:0] in_shift, out_shift;
  logic [$clog2(WORD_W+1)-1:0] bit_cnt;
  logic word_in_done;
  logic [CTRL_AW-1:0] ra;
  assign ra = comm_reg[CTRL_AW-1:0];

  // read source: result word when pending, else the addressed control register
  logic [WORD_W-1:0] read_src;
  assign read_src = result_pending ? result_word : ctrl_regs[ra];

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state <= ASP_IDLE;
      in_shift <= '0;
      out_shift <= '0;
      bit_cnt <= '0;
      word_in_done <= 1'b0;
    end else begin
      word_in_done <= 1'b0;
      case (state)
        ASP_IDLE: begin
          if (selected && sclk_fall) begin
            out_shift <= read_src;
            bit_cnt <= '0;
            state <= ASP_SHIFT;
          end
        end
        ASP_SHIFT: begin
          if (!selected) begin
            state <= ASP_IDLE;
          end else begin
            if (sclk_rise) begin
              in_shift <= {in_shift[WORD_W-2:0], din_sy[1]};
              bit_cnt <= bit_cnt + 1'b1;
              if (bit_cnt == ($clog2(WORD_W+1))'(WORD_W - 1)) begin
                word_in_done <= 1'b1;
                state <= ASP_DONE;
              end
            end
            if (sclk_fall && bit_cnt != '0) begin
              out_shift <= {out_shift[WORD_W-2:0], 1'b0};
            end
          end
        end
        ASP_DONE: begin
          if (!selected) begin
            state <= ASP_IDLE;
          end else if (sclk_fall) begin
            // back-to-back frame: this fall already carries the next msb
            out_shift <= read_src;
            bit_cnt <= '0;
            state <= ASP_SHIFT;
          end
        end
        default: state <= ASP_IDLE;
      endcase
    end
  end

  // word goes to addressed control register
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_CTRL; i++) ctrl_regs[i] <= '0;
    end else if (word_in_done) begin
      ctrl_regs[ra] <= in_shift;
    end
  end

  // ==========================================================
  // result buffering and ready indication
  logic fifo_valid;
  logic [WORD_W-1:0] fifo_data;
  logic take_result, read_done;
  assign read_done = word_in_done && result_pending;
  assign take_result = fifo_valid && !result_pending;

  asp_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(result_valid),
    .in_ready(result_ready),
    .in_data(result_data),
    .out_valid(fifo_valid),
    .out_ready(take_result),
    .out_data(fifo_data)
  );

  logic rdy_level;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      result_pending <= 1'b0;
      result_word <= '0;
      rdy_level <= 1'b1;
    end else begin
      if (take_result) begin
        result_pending <= 1'b1;
        result_word <= fifo_data;
        rdy_level <= 1'b0;
      end else if (read_done) begin
        result_pending <= 1'b0;
        rdy_level <= 1'b1;
      end else if (result_update_soon && result_pending) begin
        // unread result: back high before the update
        rdy_level <= 1'b1;
      end
    end
  end

  // release pin when deselected; ready level when idle
  assign serial_out_ready_oe = selected;
  assign serial_out_ready_o = (state == ASP_SHIFT) ? out_shift[WORD_W-1] : rdy_level;

  // ==========================================================
  // sync / fault pin
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      external_fault_flag <= 1'b0;
      align_seen <= 1'b0;
      filter_align_pulse <= 1'b0;
    end else begin
      // rising edge of the sync input realigns the filters
      filter_align_pulse <= sync_en && pin_sy[1] && !pin_d;
      if (sync_en && pin_sy[1] && !pin_d) align_seen <= 1'b1;
      // low level sets the fault flag; set wins over clear
      if (!sync_en && pin_mode == ASP_PIN_FAULT_IN && !pin_sy[1]) begin
        external_fault_flag <= 1'b1;
      end else if (wr_go && aw_addr == OFS_COMM) begin
        external_fault_flag <= 1'b0;
      end
    end
  end

  asp_pin_drv_s pin_drv;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pin_drv <= '0;
    end else begin
      pin_drv <= '0;
      if (!sync_en) begin
        case (pin_mode)
          ASP_PIN_FAULT_OUT: pin_drv <= '{o: 1'b0, oe: |error_bits};
          ASP_PIN_GP_OUT: pin_drv <= '{o: gpio_config_reg[GPC_ERR_LEVEL], oe: 1'b1};
          default: pin_drv <= '0;
        endcase
      end
    end
  end
  assign filter_align_fault_pin_o = pin_drv.o;
  assign filter_align_fault_pin_oe = pin_drv.oe;

  // ==========================================================
  // master clock source
  // four sources
  assign clock_source_sel = adc_mode_reg[ADC_MODE_CLK_LO +: 2];
  // external clock and crystal use the clock pin as input
  assign crystal_amp_en = (clock_source_sel == ASP_CLK_XTAL);
  assign xtal_clock_io_oe = (clock_source_sel == ASP_CLK_INT_OUT);
  assign xtal_clock_io_o = int_osc_clk;

  // ==========================================================
  // AXI4-Lite read path
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      OFS_GPIO_CONFIG: rd_mux = gpio_config_reg;
      OFS_ADC_MODE: rd_mux = adc_mode_reg;
      OFS_STATUS: rd_mux = status_word(external_fault_flag, error_bits, result_pending,
                                       align_seen);
      OFS_RESULT: rd_mux = result_word;
      OFS_CTRL_WORD: rd_mux = ctrl_regs[ra];
      OFS_COMM: rd_mux = comm_reg;
      default: begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
